// File: oc_response_defines.vh
`ifndef OC_RESPONSE_DEFINES_VH
`define OC_RESPONSE_DEFINES_VH

// ****************************************************************
// command codes and reset values
// ****************************************************************
`define CMD_OC_ACTION 8'h47
`define CMD_OT_ACTION 8'hd6
`define OC_ACTION_RESET 8'h00
`define OT_ACTION_FIXED 8'hc0

// ****************************************************************
// field positions of the response byte
// ****************************************************************
`define MODE_HI 7
`define MODE_LO 6
`define RETRY_HI 5
`define RETRY_LO 3
`define DELAY_HI 2
`define DELAY_LO 0

// ****************************************************************
// response mode and retry encodings
// ****************************************************************
`define MODE_CONST_CURRENT 2'h0
`define MODE_UNSUPPORTED 2'h1
`define MODE_DEGLITCH 2'h2
`define MODE_IMMEDIATE 2'h3
`define RETRY_FOREVER 3'h7

// ****************************************************************
// timing: 16 ms delay unit at 125 MHz
// ****************************************************************
`define DELAY_UNIT_NS 16000000
`define CLOCK_PERIOD_NS 8
`define DELAY_UNIT_CYCLES (`DELAY_UNIT_NS / `CLOCK_PERIOD_NS)
`define RETRY_INTERVAL_RESET 32'h0000_0100

`endif

// File: tick_divider.v
`timescale 1ns/100ps
// ****************************************************************
// one-cycle enable pulse every period_in cycles
// ****************************************************************
module tick_divider (
    // clock and reset
    input wire clock_in,
    input wire reset_in,
    // control
    input wire restart_in,
    input wire [31:0] period_in,
    // tick
    output reg tick_out
);
    reg [31:0] count_reg;

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            count_reg <= 32'h0000_0000;
            tick_out <= 1'b0;
        end else if (restart_in) begin
            count_reg <= 32'h0000_0000;
            tick_out <= 1'b0;
        end else if (count_reg + 32'h0000_0001 >= period_in) begin
            count_reg <= 32'h0000_0000;
            tick_out <= 1'b1;
        end else begin
            count_reg <= count_reg + 32'h0000_0001;
            tick_out <= 1'b0;
        end
    end
endmodule

// File: oc_fault_response.v
`timescale 1ns/100ps
`include "oc_response_defines.vh"
// Overview of operation
// [RULE1] per-channel read/write response byte at command 0x47, reset 0x00
// [RULE2] any overcurrent fault sets three status flags and asserts alert
// [RULE3] mode 00: stay in constant-current limit forever
// [RULE4] mode 10: stay current-limited for the programmed delay
// [RULE5] still limiting when delay expires: follow retry field
// [RULE6] mode 11: disable output at once then follow retry field
// [RULE7] retry 000-110: latch off until run cycled or bias lost
// [RULE8] retry 111: restart forever until commanded off or other fault
// [RULE9] restart attempts spaced by the separate restart interval setting
// [RULE10] delay bits 2:0 count 16 ms units from detection to shutdown
// [RULE11] delay count used only in deglitched shutdown mode
// [RULE12] overcurrent flags hold until clear-faults command
// [RULE13] run off then on also clears the overcurrent flags
// [RULE14] read-only overtemp response byte at 0xd6 fixed to 0xc0
// [RULE15] overtemp disables output while present, resumes automatically
// [RULE16] write of mode 01 is refused, flags a logic fault, keeps old value
// [RULE17] delay counter runs on prescaled tick, restarts per fault, clears
module oc_fault_response #(
    parameter [31:0] DELAY_UNIT_CYCLES = `DELAY_UNIT_CYCLES
) (
    // clock and reset
    input wire clock_in,
    input wire reset_in,
    // byte command port
    input wire cmd_write_in,
    input wire cmd_read_in,
    input wire [7:0] cmd_code_in,
    input wire [7:0] cmd_wdata_in,
    input wire clear_faults_in,
    output reg [7:0] cmd_rdata_out,
    output reg cmd_rvalid_out,
    // run control
    input wire channel_run_pin_in,
    input wire operation_on_in,
    input wire other_fault_in,
    input wire [31:0] restart_interval_setting_in,
    // sensed conditions
    input wire overcurrent_in,
    input wire overtemp_in,
    // outputs
    output reg output_enable_out,
    output reg current_limit_out,
    output reg status_byte_iout_oc_out,
    output reg status_word_iout_out,
    output reg status_iout_oc_out,
    output reg logic_fault_out,
    output reg alert_n_out
);
    localparam [4:0] ST_RUN = 5'h01;
    localparam [4:0] ST_LIMIT = 5'h02;
    localparam [4:0] ST_LATCHED = 5'h04;
    localparam [4:0] ST_WAIT = 5'h08;
    localparam [4:0] ST_OFF = 5'h10;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg [1:0] run_sync_reg;
    reg [1:0] oc_sync_reg;
    reg [1:0] ot_sync_reg;
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            run_sync_reg <= 2'h0;
            oc_sync_reg <= 2'h0;
            ot_sync_reg <= 2'h0;
        end else begin
            run_sync_reg <= {run_sync_reg[0], channel_run_pin_in};
            oc_sync_reg <= {oc_sync_reg[0], overcurrent_in};
            ot_sync_reg <= {ot_sync_reg[0], overtemp_in};
        end
    end
    wire run_on = run_sync_reg[1] & operation_on_in;
    wire oc_now = oc_sync_reg[1];
    wire ot_now = ot_sync_reg[1];

    reg [7:0] action_reg;
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [2:0] units_reg;
    reg run_prev_reg;
    reg oc_prev_reg;
    reg flag_reg;

    wire [1:0] mode = action_reg[`MODE_HI:`MODE_LO];
    wire [2:0] retry = action_reg[`RETRY_HI:`RETRY_LO];
    wire [2:0] delay = action_reg[`DELAY_HI:`DELAY_LO];
    wire oc_rise = oc_now & ~oc_prev_reg;
    wire run_rise = run_on & ~run_prev_reg;
    wire clear_any = clear_faults_in | run_rise;
    wire restart_timer = (state_reg != state_next) | oc_rise;

    // ****************************************************************
    // shared delay tick
    // ****************************************************************
    wire tick;
    wire [31:0] tick_period = (state_reg == ST_WAIT) ? restart_interval_setting_in : DELAY_UNIT_CYCLES;
    tick_divider divider (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .restart_in(restart_timer),
        .period_in(tick_period),
        .tick_out(tick)
    );

    // ****************************************************************
    // response state machine
    // ****************************************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (run_on) state_next = ST_RUN;
            end
            ST_RUN: begin
                if (!run_on) state_next = ST_OFF;
                else if (oc_now) begin
                    if (mode == `MODE_IMMEDIATE) state_next = (retry == `RETRY_FOREVER) ? ST_WAIT : ST_LATCHED; // see [RULE6]
                    else state_next = ST_LIMIT; // see [RULE3]
                end
            end
            ST_LIMIT: begin
                if (!run_on) state_next = ST_OFF;
                else if (!oc_now) state_next = ST_RUN;
                else if (mode == `MODE_DEGLITCH && tick && units_reg + 3'h1 >= delay) // see [RULE11]
                    state_next = (retry == `RETRY_FOREVER) ? ST_WAIT : ST_LATCHED; // see [RULE5]
                else if (mode == `MODE_IMMEDIATE) state_next = (retry == `RETRY_FOREVER) ? ST_WAIT : ST_LATCHED;
            end
            ST_WAIT: begin
                if (!run_on || other_fault_in) state_next = run_on ? ST_LATCHED : ST_OFF; // see [RULE8]
                else if (tick) state_next = ST_RUN; // see [RULE9]
            end
            ST_LATCHED: begin
                if (!run_on) state_next = ST_OFF; // see [RULE7]
            end
            default: state_next = ST_OFF;
        endcase
    end

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= ST_OFF;
            units_reg <= 3'h0;
            run_prev_reg <= 1'b0;
            oc_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            run_prev_reg <= run_on;
            oc_prev_reg <= oc_now;
            if (restart_timer || clear_any) units_reg <= 3'h0; // see [RULE17]
            else if (tick && units_reg != 3'h7) units_reg <= units_reg + 3'h1; // see [RULE10]
        end
    end

    // ****************************************************************
    // command registers and status flags
    // ****************************************************************
    wire bad_write = cmd_write_in && cmd_code_in == `CMD_OC_ACTION &&
                     cmd_wdata_in[`MODE_HI:`MODE_LO] == `MODE_UNSUPPORTED;
    wire ro_write = cmd_write_in && cmd_code_in == `CMD_OT_ACTION;
    wire flag_next = oc_now | (flag_reg & ~clear_any); // see [RULE12] [RULE13]

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            action_reg <= `OC_ACTION_RESET;
            flag_reg <= 1'b0;
            cmd_rdata_out <= 8'h00;
            cmd_rvalid_out <= 1'b0;
            status_byte_iout_oc_out <= 1'b0;
            status_word_iout_out <= 1'b0;
            status_iout_oc_out <= 1'b0;
            alert_n_out <= 1'b1;
            logic_fault_out <= 1'b0;
            output_enable_out <= 1'b0;
            current_limit_out <= 1'b0;
        end else begin
            if (cmd_write_in && cmd_code_in == `CMD_OC_ACTION && !bad_write)
                action_reg <= cmd_wdata_in; // see [RULE1]
            if (bad_write || ro_write) logic_fault_out <= 1'b1; // see [RULE16]
            else if (clear_faults_in) logic_fault_out <= 1'b0;
            cmd_rvalid_out <= cmd_read_in;
            if (cmd_read_in) begin
                case (cmd_code_in)
                    `CMD_OC_ACTION: cmd_rdata_out <= action_reg;
                    `CMD_OT_ACTION: cmd_rdata_out <= `OT_ACTION_FIXED; // see [RULE14]
                    default: cmd_rdata_out <= 8'h00;
                endcase
            end
            flag_reg <= flag_next;
            status_byte_iout_oc_out <= flag_next; // see [RULE2]
            status_word_iout_out <= flag_next;
            status_iout_oc_out <= flag_next;
            alert_n_out <= ~(flag_next | logic_fault_out);
            output_enable_out <= (state_next == ST_RUN || state_next == ST_LIMIT) && !ot_now; // see [RULE15]
            current_limit_out <= state_next == ST_LIMIT; // see [RULE4]
        end
    end
endmodule

// File: oc_fault_response_asserts.sv
`timescale 1ns/100ps
module oc_fault_response_asserts #(
    parameter [31:0] DELAY_UNIT_CYCLES = 32'h001e_8480
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // command port
    input wire logic cmd_write_in,
    input wire logic cmd_read_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] cmd_wdata_in,
    input wire logic [7:0] cmd_rdata_out,
    input wire logic cmd_rvalid_out,
    // conditions and outputs
    input wire logic overcurrent_in,
    input wire logic overtemp_in,
    input wire logic output_enable_out,
    input wire logic status_byte_iout_oc_out,
    input wire logic status_word_iout_out,
    input wire logic status_iout_oc_out,
    input wire logic logic_fault_out,
    input wire logic alert_n_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    // ****************************************************************
    // last accepted response setting
    // ****************************************************************
    logic [7:0] act_reg;
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in)
            act_reg <= 8'h00;
        else if (cmd_write_in && cmd_code_in == 8'h47 && cmd_wdata_in[7:6] != 2'h1)
            act_reg <= cmd_wdata_in;
    end
    AST_READBACK: assert property (cmd_read_in && cmd_code_in == 8'h47 |=>
        cmd_rvalid_out && cmd_rdata_out == $past(act_reg)) else $error("setting readback wrong");
    AST_OT_READ: assert property (cmd_read_in && cmd_code_in == 8'hd6 |=> cmd_rdata_out == 8'hc0)
        else $error("overtemp byte wrong");
    AST_OT_WRITE: assert property (cmd_write_in && cmd_code_in == 8'hd6 |-> ##[1:2] logic_fault_out)
        else $error("write to read-only byte not flagged");
    AST_REFUSE: assert property (cmd_write_in && cmd_code_in == 8'h47 && cmd_wdata_in[7:6] == 2'h1
        |-> ##[1:2] logic_fault_out) else $error("mode 01 not flagged");
    AST_FLAGS_TIED: assert property (status_byte_iout_oc_out == status_iout_oc_out
        && status_word_iout_out == status_iout_oc_out) else $error("status flags disagree");
    AST_FLAG_SET: assert property (overcurrent_in [*5] |-> status_iout_oc_out) else $error("flag not set");
    AST_ALERT: assert property (status_iout_oc_out |-> !alert_n_out) else $error("alert not asserted");
    AST_IMMEDIATE: assert property ($rose(status_iout_oc_out) && act_reg[7:6] == 2'h3
        |-> ##[0:2] !output_enable_out) else $error("no immediate shutdown");
    AST_OT_OFF: assert property (overtemp_in [*4] |-> !output_enable_out) else $error("on during overtemp");
endmodule
bind oc_fault_response oc_fault_response_asserts #(.DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES)) chk (
    .clock_in(clock_in), .reset_in(reset_in), .cmd_write_in(cmd_write_in), .cmd_read_in(cmd_read_in),
    .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
    .cmd_rvalid_out(cmd_rvalid_out), .overcurrent_in(overcurrent_in), .overtemp_in(overtemp_in),
    .output_enable_out(output_enable_out), .status_byte_iout_oc_out(status_byte_iout_oc_out),
    .status_word_iout_out(status_word_iout_out), .status_iout_oc_out(status_iout_oc_out),
    .logic_fault_out(logic_fault_out), .alert_n_out(alert_n_out));

// File: oc_host_model.sv
`timescale 1ns/100ps
module oc_host_model (
    // clock
    input wire logic clock_in,
    // byte commands toward the device
    output logic cmd_write_out,
    output logic cmd_read_out,
    output logic [7:0] cmd_code_out,
    output logic [7:0] cmd_wdata_out,
    output logic clear_faults_out
);
    // ****************************************************************
    // one command pulse per call; kind is {write, read, clear}
    // ****************************************************************
    initial begin
        {cmd_write_out, cmd_read_out, clear_faults_out} = 3'h0;
        {cmd_code_out, cmd_wdata_out} = 16'h0000;
    end
    task automatic send(input logic [2:0] kind, input logic [7:0] code, input logic [7:0] data);
        @(posedge clock_in);
        #1;
        {cmd_write_out, cmd_read_out, clear_faults_out} = kind;
        {cmd_code_out, cmd_wdata_out} = {code, data};
        @(posedge clock_in);
        #1;
        {cmd_write_out, cmd_read_out, clear_faults_out} = 3'h0;
        {cmd_code_out, cmd_wdata_out} = ~{code, data};
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam int UNIT = 20;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic run = 1'b1, oc = 1'b0, ot = 1'b0, op = 1'b1, of = 1'b0;
    logic wr, rd, clr, rv, oe, cl, sb, sw, si, lf, al;
    logic [7:0] code, wd, rdat, v;
    int fail_count = 0, n_checks = 0, d;
    always #4 clock_in = ~clock_in;
    oc_host_model host (.clock_in(clock_in), .cmd_write_out(wr), .cmd_read_out(rd), .cmd_code_out(code),
        .cmd_wdata_out(wd), .clear_faults_out(clr));
    oc_fault_response #(.DELAY_UNIT_CYCLES(UNIT)) dut (.clock_in(clock_in), .reset_in(reset_in),
        .cmd_write_in(wr), .cmd_read_in(rd), .cmd_code_in(code), .cmd_wdata_in(wd), .clear_faults_in(clr),
        .cmd_rdata_out(rdat), .cmd_rvalid_out(rv), .channel_run_pin_in(run), .operation_on_in(op),
        .other_fault_in(of), .restart_interval_setting_in(32'h0000_0028), .overcurrent_in(oc),
        .overtemp_in(ot), .output_enable_out(oe), .current_limit_out(cl), .status_byte_iout_oc_out(sb),
        .status_word_iout_out(sw), .status_iout_oc_out(si), .logic_fault_out(lf), .alert_n_out(al));
    // ****************************************************************
    // checking helpers
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
        host.send(3'h2, c, 8'h00);
        chk("rvalid", 8'h01, {7'h00, rv});
        chk("rdata", exp, rdat);
    endtask
    task automatic flags(input logic e);
        chk("flags", {4'h0, e, e, e, ~e}, {4'h0, sb, sw, si, al});
    endtask
    task automatic en(input logic e);
        chk("output_enable", {7'h00, e}, {7'h00, oe});
    endtask
    function automatic int off_time(input int dly);
        return (dly == 0 ? 1 : dly) * UNIT;
    endfunction
    task automatic test_done;
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(13109));
        repeat (10) @(posedge clock_in);
        #1 reset_in = 1'b0;
        rd_chk(8'h47, 8'h00);
        rd_chk(8'hd6, 8'hc0);
        repeat (6) begin
            v = 8'($urandom);
            if (v[7:6] == 2'h1) v[7] = 1'b1;
            host.send(3'h4, 8'h47, v);
            rd_chk(8'h47, v);
        end
        host.send(3'h4, 8'h47, 8'h40);
        cyc(2);
        chk("logic_fault", 8'h01, {7'h00, lf});
        rd_chk(8'h47, v);
        host.send(3'h4, 8'hd6, 8'h00);
        rd_chk(8'hd6, 8'hc0);
        host.send(3'h1, 8'h00, 8'h00);
        cyc(2);
        chk("logic_fault", 8'h00, {7'h00, lf});
        // constant-current mode with a delay count that must be ignored
        d = $urandom_range(7, 1);
        host.send(3'h4, 8'h47, {5'h00, 3'(d)});
        oc = 1'b1;
        cyc(5);
        flags(1'b1);
        chk("current_limit", 8'h01, {7'h00, cl});
        cyc(9 * UNIT);
        en(1'b1);
        oc = 1'b0;
        cyc(5);
        flags(1'b1);
        host.send(3'h1, 8'h00, 8'h00);
        cyc(2);
        flags(1'b0);
        // deglitched shutdown, latch off, cleared by run cycling
        host.send(3'h4, 8'h47, {5'h10, 3'(d)});
        oc = 1'b1;
        cyc(off_time(d) - 2);
        en(1'b1);
        cyc(12);
        en(1'b0);
        oc = 1'b0;
        cyc(50);
        en(1'b0);
        run = 1'b0;
        cyc(5);
        run = 1'b1;
        cyc(5);
        flags(1'b0);
        en(1'b1);
        // immediate shutdown with endless restart
        host.send(3'h4, 8'h47, 8'hfd);
        oc = 1'b1;
        cyc(5);
        en(1'b0);
        oc = 1'b0;
        cyc(10);
        en(1'b0);
        cyc(60);
        en(1'b1);
        // another fault while waiting stops the retries
        oc = 1'b1;
        cyc(5);
        en(1'b0);
        of = 1'b1;
        oc = 1'b0;
        cyc(60);
        en(1'b0);
        of = 1'b0;
        // operation command off then on clears the flags
        op = 1'b0;
        cyc(5);
        op = 1'b1;
        cyc(5);
        flags(1'b0);
        en(1'b1);
        ot = 1'b1;
        cyc(5);
        en(1'b0);
        ot = 1'b0;
        cyc(5);
        en(1'b1);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        fail_count++;
        test_done();
    end
endmodule
